/* design/ras_pkg.sv */
// Package for the ROM address sequencer: layout, offsets, reset values, states
package ras_pkg;

   // Program memory geometry
   localparam int RAS_WORD_W = 10;
   localparam int RAS_BANK_W = 1;
   localparam int RAS_PAGE_W = 5;
   localparam int RAS_ADDR_W = 6;
   localparam int RAS_ROM_AW = RAS_BANK_W + RAS_PAGE_W + RAS_ADDR_W;
   localparam int RAS_PAGES = 32;
   localparam int RAS_WORDS_PER_PAGE = 64;
   localparam int RAS_ROM_WORDS = 4096;

   // Subroutine space is bank 0, page 0
   localparam logic [0:0] RAS_SUB_BANK = 1'h0;
   localparam logic [4:0] RAS_SUB_PAGE = 5'h00;

   // Reset values
   localparam logic [0:0] RAS_BANK_RST = 1'h0;
   localparam logic [4:0] RAS_PAGE_RST = 5'h00;
   localparam logic [5:0] RAS_WORD_RST = 6'h3F;

   // Pattern word fields
   localparam int RAS_IO_FLAG_BIT = 9;
   localparam int RAS_ACC_FLAG_BIT = 8;

   // Register byte offsets
   localparam logic [7:0] RAS_OFS_PC = 8'h00;
   localparam logic [7:0] RAS_OFS_ACCB = 8'h04;
   localparam logic [7:0] RAS_OFS_PAT = 8'h08;
   localparam logic [7:0] RAS_OFS_IO = 8'h0C;
   localparam logic [7:0] RAS_OFS_STAT = 8'h10;

   // Field positions in the registers
   localparam int RAS_ACCB_B_LSB = 4;
   localparam int RAS_ACCB_C_BIT = 8;
   localparam int RAS_STAT_BUSY_BIT = 12;
   localparam int RAS_STAT_HALT_BIT = 13;

   typedef struct packed {
      logic [0:0] bank;
      logic [4:0] page;
      logic [5:0] word;
   } ras_pc_t;

   typedef struct packed {
      logic io_flag;
      logic acc_flag;
      logic [3:0] high;
      logic [3:0] low;
   } ras_pat_word_t;

   typedef enum logic [1:0] {
      RAS_IDLE,
      RAS_PAT_ADDR,
      RAS_PAT_LOAD
   } ras_state_t;

endpackage

/* design/ras_rom_address_sequencer.sv */
// ROM address sequencer: program counter, pattern fetch and AHB-Lite register file
//
// Contract
// RQ1 - Halt input low freezes every piece of core state.
// RQ2 - Halt released resumes from the held state, nothing reinitialised.
// RQ3 - Reset pin high resets the block, alongside the built-in clear.
// RQ4 - Program memory is 10-bit words, two banks of 32 pages of 64.
// RQ5 - Bank 0 page 0 is the subroutine space.
// RQ6 - Counter is a 1-bit bank, 5-bit page and word part.
// RQ7 - Bank and page hold until explicitly loaded.
// RQ8 - Word part steps each cycle as polynomial counter 3F,3E,3D... 1F.
// RQ9 - Word sequence is closed and never carries into page or bank.
// RQ10 - Pattern address: word from A and B low, page ORed with B high, C, p.
// RQ11 - Pattern operand is three bits, top bit picks the bank.
// RQ12 - Pattern bank is current bank OR operand top bit.
// RQ13 - Pattern fetch leaves the counter untouched, then it steps normally.
// RQ14 - A pattern instruction takes exactly two instruction cycles.
// RQ15 - Pattern top bits select loading A/B, io registers two/three, or both.
// RQ16 - Page bits are {p1,p0,C,B3,B2}, word bits are {B1,B0,A}.
`timescale 1ns/1ps

module ras_rom_address_sequencer
   import ras_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Core control inputs
   input wire logic reset_pin,
   input wire logic built_in_power_on_clear,
   input wire logic halt_request_n,
   // Program ROM
   output logic [ras_pkg::RAS_ROM_AW-1:0] rom_addr,
   input wire logic [ras_pkg::RAS_WORD_W-1:0] rom_data,
   // Observed state
   output ras_pkg::ras_pc_t program_counter,
   output logic in_subroutine_space,
   output logic [3:0] io_register_two,
   output logic [3:0] io_register_three
);
   import ras_pkg::*;

   ras_pc_t pc_reg;
   ras_pc_t pc_next;
   ras_state_t state_reg;
   logic [3:0] acc_reg;
   logic [3:0] b_reg;
   logic carry_reg;
   logic [2:0] operand_reg;
   logic [3:0] io_two_reg;
   logic [3:0] io_three_reg;
   logic [RAS_ROM_AW-1:0] rom_addr_reg;
   logic [RAS_ROM_AW-1:0] rom_addr_next;
   logic sub_space_reg;
   logic [31:0] hrdata_reg;
   logic soft_reset;
   logic run;

   // Data phase bookkeeping
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic addr_phase;
   logic [31:0] rd_mux;
   logic wr_pc;
   logic wr_accb;
   logic wr_pat;

   ras_pc_t pat_addr;
   ras_pat_word_t pat_word;
   logic [5:0] word_step;

   assign soft_reset = reset_pin | built_in_power_on_clear; // [RQ3]
   assign run = halt_request_n; // [RQ1]
   assign addr_phase = hsel & htrans[1] & hready;
   assign pat_word = ras_pat_word_t'(rom_data); // [RQ4]

   // Write strobes; core state writes are dropped during halt to keep it frozen
   assign wr_pc = wr_pend_reg & (wr_addr_reg == RAS_OFS_PC) & run; // [RQ1]
   assign wr_accb = wr_pend_reg & (wr_addr_reg == RAS_OFS_ACCB) & run;
   assign wr_pat = wr_pend_reg & (wr_addr_reg == RAS_OFS_PAT) & run
      & (state_reg == RAS_IDLE);

   // Polynomial step: XNOR feedback with all-ones fix-up gives all 64 states
   assign word_step = {pc_reg.word[4:0],
      ~(pc_reg.word[5] ^ pc_reg.word[4]) ^ (&pc_reg.word[4:0])}; // [RQ8] [RQ9]

   // Pattern address; the counter itself is not touched
   // Operand taken from the write data, its latch would be one edge late
   always_comb
   begin
      pat_addr.word = {b_reg[1:0], acc_reg}; // [RQ10] [RQ16]
      pat_addr.page = pc_reg.page
         | {hwdata[1:0], carry_reg, b_reg[3:2]}; // [RQ10] [RQ16]
      pat_addr.bank = pc_reg.bank | hwdata[2]; // [RQ11] [RQ12]
   end

   // Counter next value: bank/page only change on an explicit load
   always_comb
   begin
      pc_next = pc_reg;
      if (wr_pc)
      begin
         pc_next.bank = hwdata[RAS_PAGE_W]; // [RQ6] [RQ7]
         pc_next.page = hwdata[RAS_PAGE_W-1:0]; // [RQ6] [RQ7]
      end
      // First cycle of a pattern does not count; the second one does
      if (state_reg != RAS_PAT_ADDR)
      begin
         pc_next.word = word_step; // [RQ8] [RQ13] [RQ14]
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pc_reg <= '{bank: RAS_BANK_RST, page: RAS_PAGE_RST, word: RAS_WORD_RST};
      end
      else if (soft_reset)
      begin
         pc_reg <= '{bank: RAS_BANK_RST, page: RAS_PAGE_RST, word: RAS_WORD_RST};
      end
      else if (run)
      begin
         pc_reg <= pc_next; // [RQ1] [RQ2]
      end
   end

   // Pattern sequencing: address cycle, then load cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= RAS_IDLE;
      end
      else if (soft_reset)
      begin
         state_reg <= RAS_IDLE;
      end
      else if (run)
      begin
         case (state_reg)
            RAS_IDLE:
            begin
               if (wr_pat)
               begin
                  state_reg <= RAS_PAT_ADDR;
               end
            end
            RAS_PAT_ADDR:
            begin
               state_reg <= RAS_PAT_LOAD; // [RQ14]
            end
            RAS_PAT_LOAD:
            begin
               state_reg <= RAS_IDLE;
            end
            default:
            begin
               state_reg <= RAS_IDLE;
            end
         endcase
      end
   end

   // Operand latched with the pattern command
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         operand_reg <= 3'h0;
      end
      else if (soft_reset)
      begin
         operand_reg <= 3'h0;
      end
      else if (wr_pat)
      begin
         operand_reg <= hwdata[2:0]; // [RQ11]
      end
   end

   // Accumulator, B and carry: software writes; pattern loads A and B only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc_reg <= 4'h0;
         b_reg <= 4'h0;
         carry_reg <= 1'b0;
      end
      else if (soft_reset)
      begin
         acc_reg <= 4'h0;
         b_reg <= 4'h0;
         carry_reg <= 1'b0;
      end
      else if (run && state_reg == RAS_PAT_LOAD && pat_word.acc_flag)
      begin
         b_reg <= pat_word.high; // [RQ15]
         acc_reg <= {pat_word.low[0], pat_word.low[1], pat_word.low[2], pat_word.low[3]};
      end
      else if (wr_accb)
      begin
         acc_reg <= hwdata[3:0];
         b_reg <= hwdata[RAS_ACCB_B_LSB +: 4];
         carry_reg <= hwdata[RAS_ACCB_C_BIT];
      end
   end

   // I/O registers two and three, loaded nibble-reversed
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         io_two_reg <= 4'h0;
         io_three_reg <= 4'h0;
      end
      else if (soft_reset)
      begin
         io_two_reg <= 4'h0;
         io_three_reg <= 4'h0;
      end
      else if (run && state_reg == RAS_PAT_LOAD && pat_word.io_flag)
      begin
         io_two_reg <= {pat_word.high[0], pat_word.high[1], pat_word.high[2],
            pat_word.high[3]}; // [RQ15]
         io_three_reg <= {pat_word.low[0], pat_word.low[1], pat_word.low[2],
            pat_word.low[3]}; // [RQ15]
      end
   end

   // ROM address: pattern address stands both cycles so the load sees its word
   always_comb
   begin
      if (state_reg == RAS_IDLE && wr_pat)
      begin
         rom_addr_next = pat_addr; // [RQ10] [RQ13]
      end
      else if (state_reg == RAS_PAT_ADDR)
      begin
         rom_addr_next = rom_addr_reg; // [RQ14] [RQ15]
      end
      else
      begin
         rom_addr_next = pc_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rom_addr_reg <= {RAS_BANK_RST, RAS_PAGE_RST, RAS_WORD_RST};
         sub_space_reg <= 1'b1;
      end
      else if (soft_reset)
      begin
         rom_addr_reg <= {RAS_BANK_RST, RAS_PAGE_RST, RAS_WORD_RST};
         sub_space_reg <= 1'b1;
      end
      else if (run)
      begin
         rom_addr_reg <= rom_addr_next;
         sub_space_reg <= (pc_next.bank == RAS_SUB_BANK)
            && (pc_next.page == RAS_SUB_PAGE); // [RQ5]
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   always_comb
   begin
      case (haddr[7:0])
         RAS_OFS_PC: rd_mux = {20'h00000, pc_reg};
         RAS_OFS_ACCB: rd_mux = {23'h00000, carry_reg, b_reg, acc_reg};
         RAS_OFS_PAT: rd_mux = {29'h0000000, operand_reg};
         RAS_OFS_IO: rd_mux = {24'h000000, io_three_reg, io_two_reg};
         RAS_OFS_STAT: rd_mux = {18'h0000, ~run, (state_reg != RAS_IDLE), rom_addr_reg};
         default: rd_mux = 32'h00000000;
      endcase
      if (haddr[31:8] != 24'h000000)
      begin
         rd_mux = 32'h00000000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end
      else
      begin
         wr_pend_reg <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
         if (addr_phase)
         begin
            wr_addr_reg <= haddr[7:0];
            hrdata_reg <= hwrite ? 32'h00000000 : rd_mux;
         end
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rom_addr = rom_addr_reg;
   assign program_counter = pc_reg;
   assign in_subroutine_space = sub_space_reg;
   assign io_register_two = io_two_reg;
   assign io_register_three = io_three_reg;

endmodule

/* testbench/ras_assertions.sv */
// Concurrent checks on the ROM address sequencer ports
`timescale 1ns/1ps
module ras_assertions
(
   // Clock and resets
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic reset_pin,
   input wire logic built_in_power_on_clear,
   input wire logic halt_request_n,
   // Observed state
   input wire logic [ras_pkg::RAS_ROM_AW-1:0] rom_addr,
   input wire ras_pkg::ras_pc_t program_counter,
   input wire logic in_subroutine_space,
   input wire logic [3:0] io_register_two,
   input wire logic [3:0] io_register_three
);
   import ras_pkg::*;
   default clocking @(posedge hclk);
   endclocking
   // Skip the edge that releases reset: its attempt would see reset values
   logic live_reg;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         live_reg <= 1'b0;
      end
      else
      begin
         live_reg <= 1'b1;
      end
   end
   default disable iff (!hresetn || !live_reg);
   logic run, pat;
   logic [5:0] w, nw;
   assign run = halt_request_n && !reset_pin && !built_in_power_on_clear;
   // Fetch address leaves the counter only while a pattern is read
   assign pat = rom_addr != program_counter;
   assign w = program_counter.word;
   assign nw = {w[4:0], ~(w[5] ^ w[4]) ^ (&w[4:0])};
   AST_HALT_HOLD:
   assert property (!halt_request_n && !reset_pin && !built_in_power_on_clear |=>
      $stable(program_counter) && $stable({io_register_two, io_register_three}))
      else $error("state moved in halt");
   AST_WORD_STEP:
   assert property (run && !pat |=> w == $past(nw))
      else $error("word step wrong");
   AST_PAT_TWO:
   assert property (run && $rose(pat) ##1 run |-> pat ##1 !pat)
      else $error("pattern not two cycles");
   AST_PAT_BANK:
   assert property (pat && program_counter.bank |-> rom_addr[11])
      else $error("pattern left bank one");
   AST_PAT_PAGE:
   assert property (pat |-> (rom_addr[10:6] | program_counter.page) == rom_addr[10:6])
      else $error("pattern page bit lost");
   AST_SUB_SPACE:
   assert property (in_subroutine_space == (program_counter[11:6] == 6'h00))
      else $error("subroutine flag wrong");
   AST_SYNC_RESET:
   assert property ((reset_pin || built_in_power_on_clear) && halt_request_n |=>
      program_counter == 12'h03F && {io_register_two, io_register_three} == 8'h00)
      else $error("sync reset missed");
   AST_IO_KEEP:
   assert property (run && !pat |=> $stable({io_register_two, io_register_three}))
      else $error("io registers moved");
endmodule
bind ras_rom_address_sequencer ras_assertions i_ras_assertions (.hclk(hclk),
   .hresetn(hresetn), .reset_pin(reset_pin),
   .built_in_power_on_clear(built_in_power_on_clear), .halt_request_n(halt_request_n),
   .rom_addr(rom_addr), .program_counter(program_counter),
   .in_subroutine_space(in_subroutine_space), .io_register_two(io_register_two),
   .io_register_three(io_register_three));

/* testbench/ras_rom_address_sequencer_tb.sv */
// Self-checking bench for the ROM address sequencer
`timescale 1ns/1ps
module ras_rom_address_sequencer_tb;
   import ras_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, reset_pin, clr, halt_n, sub;
   logic [31:0] haddr, hwdata, hrdata, rd, v;
   logic [31:0] seed = 32'hE8234BC3;
   logic [1:0] htrans;
   logic [11:0] rom_addr, ea, w0;
   logic [9:0] rom_data, rw;
   logic [3:0] io2, io3, o2, o3;
   logic [5:0] w;
   ras_pc_t pc;
   int fails = 0;
   int compares = 0;
   logic [5:0] seq[$] = '{6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h37, 6'h2F, 6'h1E, 6'h3C};
   ras_rom_address_sequencer i_ras_rom_address_sequencer (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .reset_pin(reset_pin), .built_in_power_on_clear(clr), .halt_request_n(halt_n),
      .rom_addr(rom_addr), .rom_data(rom_data), .program_counter(pc),
      .in_subroutine_space(sub), .io_register_two(io2), .io_register_three(io3));
   ras_rom_model i_ras_rom_model (.rom_addr(rom_addr), .rom_data(rom_data));
   function automatic logic [5:0] step(logic [5:0] x);
      return {x[4:0], ~(x[5] ^ x[4]) ^ (&x[4:0])};
   endfunction
   function automatic logic [3:0] rv(logic [3:0] x);
      return {x[0], x[1], x[2], x[3]};
   endfunction
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Slave may stretch; never wait for it forever
   task automatic edge_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            fails++;
            stop_test();
         end
         @(posedge hclk);
      end
   endtask
   task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      rd = hrdata;
   endtask
   initial
   begin
      hclk = 1'b0;
      forever
         #5 hclk = ~hclk;
   end
   initial
   begin
      {hresetn, hsel, hwrite, reset_pin, clr} = 5'h00;
      {haddr, hwdata, htrans} = 66'h0;
      halt_n = 1'b1;
      repeat (20) @(posedge hclk);
      check({sub, pc}, 13'h103F);
      hresetn <= 1'b1;
      foreach (seq[i])
      begin
         #1;
         check(pc.word, seq[i]);
         @(posedge hclk);
      end
      #1;
      w0 = pc;
      w = w0[5:0];
      repeat (63)
      begin
         @(posedge hclk);
         #1;
         w = step(w);
         check(pc, {w0[11:6], w});
      end
      @(posedge hclk);
      halt_n <= 1'b0;
      #1;
      w0 = pc;
      @(posedge hclk);
      bus(1'b1, RAS_OFS_PC, 32'h3F);
      bus(1'b0, RAS_OFS_STAT, 32'h0);
      check(rd[13:0], {2'h2, w0});
      repeat (5) @(posedge hclk);
      halt_n <= 1'b1;
      #1;
      check(pc, w0);
      @(posedge hclk);
      #1;
      check(pc, {w0[11:6], step(w0[5:0])});
      repeat (4)
      begin
         v = xs();
         @(posedge hclk);
         bus(1'b1, RAS_OFS_PC, v & 32'h3F);
         #1;
         check(pc[11:6], v[5:0]);
         @(posedge hclk);
         bus(1'b0, RAS_OFS_PC, 32'h0);
         check(rd[11:6], v[5:0]);
      end
      for (int p = 0; p < 8; p++)
      begin
         v = xs();
         @(posedge hclk);
         bus(1'b1, RAS_OFS_PC, v[14:9]);
         bus(1'b1, RAS_OFS_ACCB, v[8:0]);
         bus(1'b1, RAS_OFS_PAT, p);
         #1;
         w0 = pc;
         {o2, o3} = {io2, io3};
         ea = {w0[11] | p[2], w0[10:6] | {p[1:0], v[8:6]}, v[5:0]};
         rw = ea[9:0] ^ {ea[11:10], 8'hA5};
         check(rom_addr, ea);
         repeat (2) @(posedge hclk);
         #1;
         check(rom_addr, {w0[11:6], step(w0[5:0])});
         check({io2, io3}, rw[9] ? {rv(rw[7:4]), rv(rw[3:0])} : {o2, o3});
         @(posedge hclk);
         bus(1'b0, RAS_OFS_ACCB, 32'h0);
         check(rd[7:0], rw[8] ? {rw[7:4], rv(rw[3:0])} : v[7:0]);
         if (rw[9])
            {o2, o3} = {rv(rw[7:4]), rv(rw[3:0])};
         bus(1'b0, RAS_OFS_IO, 32'h0);
         check(rd[7:0], {o3, o2});
         bus(1'b0, RAS_OFS_PAT, 32'h0);
         check(rd[2:0], p[2:0]);
      end
      for (int i = 0; i < 2; i++)
      begin
         @(posedge hclk);
         reset_pin <= (i == 0);
         clr <= (i == 1);
         @(posedge hclk);
         reset_pin <= 1'b0;
         clr <= 1'b0;
         #1;
         check({pc, io2, io3}, 20'h03F00);
      end
      @(posedge hclk);
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      check(hresp, 1'b0);
      stop_test();
   end
endmodule

/* testbench/ras_rom_model.sv */
// Behavioural program ROM facing the sequencer
`timescale 1ns/1ps
module ras_rom_model
(
   // Fetch port
   input wire logic [ras_pkg::RAS_ROM_AW-1:0] rom_addr,
   output logic [ras_pkg::RAS_WORD_W-1:0] rom_data
);
   import ras_pkg::*;
   // Word mixes its own address so every fetch is predictable
   assign rom_data = rom_addr[9:0] ^ {rom_addr[11:10], 8'hA5};
endmodule
